// ---- smacu_regs.vh ----
// Constants for the signed multiply-accumulate unit: encodings, fields, kinds.
// Assumes the 32-bit instruction word carries the first halfword in bits 31:16.
`ifndef SMACU_REGS_VH
`define SMACU_REGS_VH

// First-halfword opcode, bits 31:20 of the instruction word
`define SMACU_OP_HALF 12'hfb1
`define SMACU_OP_DUAL 12'hfb2
`define SMACU_OP_LONG 12'hfbc

// Field positions inside the instruction word
`define SMACU_F_RN 19:16
`define SMACU_F_RA 15:12
`define SMACU_F_RD 11:8
`define SMACU_F_RM 3:0
`define SMACU_F_N 5
`define SMACU_F_M 4
`define SMACU_F_OPC 31:20

// Second-halfword sub-opcode values
`define SMACU_SUB_HALF 2'b00
`define SMACU_SUB_DUAL 3'b000
`define SMACU_SUB_LWORD 4'h0
`define SMACU_SUB_LHALF 2'b10
`define SMACU_SUB_LDUAL 3'b110

// Register numbers with special meaning
`define SMACU_REG_SP 4'hd
`define SMACU_REG_PC 4'hf
`define SMACU_REG_NONE 4'hf

// Instruction kinds
`define SMACU_K_NONE 3'h0
`define SMACU_K_HALF 3'h1
`define SMACU_K_DUAL 3'h2
`define SMACU_K_LWORD 3'h3
`define SMACU_K_LHALF 3'h4
`define SMACU_K_LDUAL 3'h5

// Cycles from an accepted instruction to its result
`define SMACU_LATENCY 2

`endif

// ---- smacu_smul.v ----
// Registered signed multiplier of two W-bit operands.
// Assumes operands are stable in the cycle they are presented.
`timescale 1ns/1ns
module smacu_smul #(
    parameter W = 16
) (
    input wire i_clk,
    input wire i_rst,
    input wire [W-1:0] i_a,
    input wire [W-1:0] i_b,
    output wire [2*W-1:0] o_p
);

    // Product register, one cycle after the operands
    reg [2*W-1:0] prod_ff;
    wire [2*W-1:0] nxt_prod;

    // Full-width product, no overflow possible
    assign nxt_prod = $signed(i_a) * $signed(i_b);

    // Clear at reset so stale products never leak
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            prod_ff <= {(2*W){1'b0}};
        else
            prod_ff <= nxt_prod;
    end

    assign o_p = prod_ff;

endmodule

// ---- smacu_dec.v ----
// Combinational decoder for the multiply-accumulate encodings.
// Assumes a 32-bit instruction word; anything else decodes as kind none.
`timescale 1ns/1ns
`include "smacu_regs.vh"
module smacu_dec (
    input wire [31:0] i_instr,
    output reg [2:0] o_kind,
    output wire o_plain,
    output wire o_n_high,
    output wire o_m_high,
    output wire o_unpred,
    output wire o_same_dest
);

    wire [3:0] rn;
    wire [3:0] rm;
    wire [3:0] ra;
    wire [3:0] rd;
    wire [11:0] opc;

    // Field extraction
    assign rn = i_instr[`SMACU_F_RN];
    assign rm = i_instr[`SMACU_F_RM];
    assign ra = i_instr[`SMACU_F_RA];
    assign rd = i_instr[`SMACU_F_RD];
    assign opc = i_instr[`SMACU_F_OPC];

    // Stack pointer or program counter in a register field
    function bad_reg;
        input [3:0] r;
        begin
            bad_reg = (r == `SMACU_REG_SP) || (r == `SMACU_REG_PC);
        end
    endfunction

    // Kind from opcode and sub-opcode
    always @*
    begin
        o_kind = `SMACU_K_NONE;
        if (opc == `SMACU_OP_HALF && i_instr[7:6] == `SMACU_SUB_HALF)
            o_kind = `SMACU_K_HALF;
        else if (opc == `SMACU_OP_DUAL && i_instr[7:5] == `SMACU_SUB_DUAL)
            o_kind = `SMACU_K_DUAL;
        else if (opc == `SMACU_OP_LONG && i_instr[7:4] == `SMACU_SUB_LWORD)
            o_kind = `SMACU_K_LWORD;
        else if (opc == `SMACU_OP_LONG && i_instr[7:6] == `SMACU_SUB_LHALF)
            o_kind = `SMACU_K_LHALF;
        else if (opc == `SMACU_OP_LONG && i_instr[7:5] == `SMACU_SUB_LDUAL)
            o_kind = `SMACU_K_LDUAL;
    end

    // Accumulator field all ones on a 32-bit form means no accumulate
    assign o_plain = (ra == `SMACU_REG_NONE);
    assign o_n_high = i_instr[`SMACU_F_N];
    assign o_m_high = i_instr[`SMACU_F_M];

    // Forbidden register numbers; accumulator checked only when used
    assign o_unpred = bad_reg(rn) || bad_reg(rm) || bad_reg(rd) ||
        ((o_kind == `SMACU_K_HALF || o_kind == `SMACU_K_DUAL) ?
        (ra == `SMACU_REG_SP) : bad_reg(ra));
    // Long forms naming one register for both halves
    assign o_same_dest = (ra == rd);

endmodule

// ---- smacu_core.v ----
// Signed multiply-accumulate datapath: halfword, dual and long forms.
// Assumes the register file answers the read indices in the same cycle,
// and that the status word clear comes from the core's flag-write logic.
`timescale 1ns/1ns
`include "smacu_regs.vh"
module smacu_core #(
    parameter XLEN = 32
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_valid,
    input wire [31:0] i_instr,
    input wire i_cond_pass,
    input wire i_dsp_ext,
    input wire i_main_ext,
    output wire [3:0] o_rn_idx,
    output wire [3:0] o_rm_idx,
    output wire [3:0] o_ra_idx,
    output wire [3:0] o_rd_idx,
    input wire [XLEN-1:0] i_rn_val,
    input wire [XLEN-1:0] i_rm_val,
    input wire [XLEN-1:0] i_ra_val,
    input wire [XLEN-1:0] i_rd_val,
    input wire i_sat_clear,
    output wire o_done,
    output wire o_undef,
    output wire o_unpred,
    output wire o_wr_en,
    output wire [3:0] o_wr_idx,
    output wire [XLEN-1:0] o_wr_data,
    output wire o_wr_hi_en,
    output wire [3:0] o_wr_hi_idx,
    output wire [XLEN-1:0] o_wr_hi_data,
    output wire o_sat_flag
);

    localparam HW = XLEN / 2;
    localparam DW = 2 * XLEN;

    // Decoder outputs
    wire [2:0] dec_kind;
    wire dec_plain;
    wire dec_n_high;
    wire dec_m_high;
    wire dec_unpred;
    wire dec_same;

    // Operand selection
    reg [HW-1:0] lane0_a;
    reg [HW-1:0] lane0_b;
    wire [XLEN-1:0] op2;
    wire [XLEN-1:0] p0;
    wire [XLEN-1:0] p1;
    wire [DW-1:0] pw;

    // Stage one state
    reg s1_vld_ff;
    reg [2:0] s1_kind_ff;
    reg [DW-1:0] s1_acc_ff;
    reg s1_write_ff;
    reg s1_undef_ff;
    reg s1_unpred_ff;
    reg [3:0] s1_lo_idx_ff;
    reg [3:0] s1_hi_idx_ff;
    reg [2:0] nxt_s1_kind;
    reg [DW-1:0] nxt_s1_acc;
    reg nxt_s1_write;
    reg nxt_s1_undef;

    // Stage two state, the visible results
    reg done_ff;
    reg undef_ff;
    reg unpred_ff;
    reg wr_en_ff;
    reg [3:0] wr_idx_ff;
    reg [XLEN-1:0] wr_data_ff;
    reg wr_hi_en_ff;
    reg [3:0] wr_hi_idx_ff;
    reg [XLEN-1:0] wr_hi_data_ff;
    reg sat_ff;
    reg [DW-1:0] sum;
    reg ovf;
    reg is_long;
    wire nxt_sat;

    // Sign extension of a word to a doubleword
    function [DW-1:0] sext;
        input [XLEN-1:0] v;
        begin
            sext = {{XLEN{v[XLEN-1]}}, v};
        end
    endfunction

    // Kind is one of the 32-bit accumulate groups
    function is_short;
        input [2:0] k;
        begin
            is_short = (k == `SMACU_K_HALF) || (k == `SMACU_K_DUAL);
        end
    endfunction

    smacu_dec u_dec (
        .i_instr(i_instr),
        .o_kind(dec_kind),
        .o_plain(dec_plain),
        .o_n_high(dec_n_high),
        .o_m_high(dec_m_high),
        .o_unpred(dec_unpred),
        .o_same_dest(dec_same)
    );

    // Read indices straight from the fields
    assign o_rn_idx = i_instr[`SMACU_F_RN];
    assign o_rm_idx = i_instr[`SMACU_F_RM];
    assign o_ra_idx = i_instr[`SMACU_F_RA];
    assign o_rd_idx = i_instr[`SMACU_F_RD];

    // Exchange: rotate second source by one halfword
    assign op2 = (dec_m_high && (dec_kind == `SMACU_K_DUAL ||
        dec_kind == `SMACU_K_LDUAL)) ?
        {i_rm_val[HW-1:0], i_rm_val[XLEN-1:HW]} : i_rm_val;

    // Lane zero: selected halves, or lower halves on dual forms
    always @*
    begin
        lane0_a = i_rn_val[HW-1:0];
        lane0_b = op2[HW-1:0];
        if (dec_kind == `SMACU_K_HALF || dec_kind == `SMACU_K_LHALF)
        begin
            // Upper half when the select bit is set
            if (dec_n_high)
                lane0_a = i_rn_val[XLEN-1:HW];
            if (dec_m_high)
                lane0_b = i_rm_val[XLEN-1:HW];
        end
    end

    // Halfword lanes; lane one only matters on dual forms
    smacu_smul #(
        .W(HW)
    ) u_lane0 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_a(lane0_a),
        .i_b(lane0_b),
        .o_p(p0)
    );

    smacu_smul #(
        .W(HW)
    ) u_lane1 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_a(i_rn_val[XLEN-1:HW]),
        .i_b(op2[XLEN-1:HW]),
        .o_p(p1)
    );

    // Full word multiplier for the word long form
    smacu_smul #(
        .W(XLEN)
    ) u_word (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_a(i_rn_val),
        .i_b(i_rm_val),
        .o_p(pw)
    );

    // Stage one: accumulator, legality and write permission
    always @*
    begin
        nxt_s1_kind = dec_kind;
        nxt_s1_acc = {DW{1'b0}};
        nxt_s1_undef = 1'b0;
        nxt_s1_write = 1'b0;
        if (is_short(dec_kind))
        begin
            // Plain multiply adds zero instead of a register
            if (!dec_plain)
                nxt_s1_acc = sext(i_ra_val);
        end
        else if (dec_kind != `SMACU_K_NONE)
        begin
            // High word above low word
            nxt_s1_acc = {i_rd_val, i_ra_val};
        end
        // Word long needs the main extension, the rest the other one
        if (dec_kind == `SMACU_K_LWORD)
            nxt_s1_undef = !i_main_ext;
        else if (dec_kind != `SMACU_K_NONE)
            nxt_s1_undef = !i_dsp_ext;
        // Unpredictable registers still execute; this keeps the path simple
        nxt_s1_write = i_valid && (dec_kind != `SMACU_K_NONE) &&
            !nxt_s1_undef && i_cond_pass;
        // Shared high and low destination: nothing written
        if (!is_short(dec_kind) && dec_same)
            nxt_s1_write = 1'b0;
    end

    // Stage one registers
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_vld_ff <= 1'b0;
            s1_kind_ff <= `SMACU_K_NONE;
            s1_acc_ff <= {DW{1'b0}};
            s1_write_ff <= 1'b0;
            s1_undef_ff <= 1'b0;
            s1_unpred_ff <= 1'b0;
            s1_lo_idx_ff <= 4'h0;
            s1_hi_idx_ff <= 4'h0;
        end
        else
        begin
            // Only recognised encodings travel down the pipe
            s1_vld_ff <= i_valid && (dec_kind != `SMACU_K_NONE);
            s1_kind_ff <= nxt_s1_kind;
            s1_acc_ff <= nxt_s1_acc;
            s1_write_ff <= nxt_s1_write;
            s1_undef_ff <= i_valid && nxt_s1_undef;
            s1_unpred_ff <= i_valid && dec_unpred;
            s1_lo_idx_ff <= i_instr[`SMACU_F_RA];
            s1_hi_idx_ff <= i_instr[`SMACU_F_RD];
        end
    end

    // Stage two: sum in doubleword precision and overflow check
    always @*
    begin
        sum = s1_acc_ff;
        is_long = 1'b0;
        case (s1_kind_ff)
            `SMACU_K_HALF:
                sum = sext(p0) + s1_acc_ff;
            `SMACU_K_DUAL:
                sum = sext(p0) + sext(p1) + s1_acc_ff;
            `SMACU_K_LWORD:
            begin
                sum = pw + s1_acc_ff;
                is_long = 1'b1;
            end
            `SMACU_K_LHALF:
            begin
                // Product widened with its sign first
                sum = sext(p0) + s1_acc_ff;
                is_long = 1'b1;
            end
            `SMACU_K_LDUAL:
            begin
                sum = sext(p0) + sext(p1) + s1_acc_ff;
                is_long = 1'b1;
            end
            default:
                sum = s1_acc_ff;
        endcase
        // Exact result must fit the sign-extended low word
        ovf = !is_long && (sum != sext(sum[XLEN-1:0]));
    end

    // Sticky flag: hardware set beats a same-cycle clear
    assign nxt_sat = (s1_write_ff && ovf) ? 1'b1 :
        (i_sat_clear ? 1'b0 : sat_ff);

    // Stage two registers
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            done_ff <= 1'b0;
            undef_ff <= 1'b0;
            unpred_ff <= 1'b0;
            wr_en_ff <= 1'b0;
            wr_idx_ff <= 4'h0;
            wr_data_ff <= {XLEN{1'b0}};
            wr_hi_en_ff <= 1'b0;
            wr_hi_idx_ff <= 4'h0;
            wr_hi_data_ff <= {XLEN{1'b0}};
            sat_ff <= 1'b0;
        end
        else
        begin
            done_ff <= s1_vld_ff;
            undef_ff <= s1_undef_ff;
            unpred_ff <= s1_unpred_ff && s1_vld_ff;
            sat_ff <= nxt_sat;
            // Low word always goes out; destination depends on group
            wr_en_ff <= s1_write_ff;
            wr_data_ff <= sum[XLEN-1:0];
            wr_idx_ff <= is_long ? s1_lo_idx_ff : s1_hi_idx_ff;
            // High word only on long forms
            wr_hi_en_ff <= s1_write_ff && is_long;
            wr_hi_idx_ff <= s1_hi_idx_ff;
            wr_hi_data_ff <= sum[DW-1:XLEN];
        end
    end

    // Registered results
    assign o_done = done_ff;
    assign o_undef = undef_ff;
    assign o_unpred = unpred_ff;
    assign o_wr_en = wr_en_ff;
    assign o_wr_idx = wr_idx_ff;
    assign o_wr_data = wr_data_ff;
    assign o_wr_hi_en = wr_hi_en_ff;
    assign o_wr_hi_idx = wr_hi_idx_ff;
    assign o_wr_hi_data = wr_hi_data_ff;
    assign o_sat_flag = sat_ff;

endmodule

// ---- smacu_chk_sva.sv ----
// Checker for the multiply-accumulate unit, bound onto smacu_core.
// Assumes the two-cycle answer and the encodings of the shared header.
`timescale 1ns/1ns
`include "smacu_regs.vh"
module smacu_chk (
    input wire i_clk,
    input wire i_rst,
    input wire i_valid,
    input wire [31:0] i_instr,
    input wire i_cond_pass,
    input wire i_dsp_ext,
    input wire i_main_ext,
    input wire i_sat_clear,
    input wire o_done,
    input wire o_undef,
    input wire o_wr_en,
    input wire [3:0] o_wr_idx,
    input wire o_wr_hi_en,
    input wire [3:0] o_wr_hi_idx,
    input wire o_sat_flag
);
    // Classes decoded here so the checks do not lean on the design decoder
    wire [11:0] opc = i_instr[`SMACU_F_OPC];
    wire half_w = opc == `SMACU_OP_HALF && i_instr[7:6] == `SMACU_SUB_HALF;
    wire lword_w = opc == `SMACU_OP_LONG && i_instr[7:4] == `SMACU_SUB_LWORD;
    wire lrest_w = i_instr[7:6] == `SMACU_SUB_LHALF || i_instr[7:5] == `SMACU_SUB_LDUAL;
    wire long_w = lword_w || (opc == `SMACU_OP_LONG && lrest_w);
    wire same_w = i_instr[15:12] == i_instr[11:8]; // Both halves aimed at one register

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Request phases, fused into the properties below
    sequence s_half_go;
        i_valid && half_w && i_dsp_ext && i_cond_pass;
    endsequence
    sequence s_long_go;
        i_valid && long_w && i_cond_pass;
    endsequence

    a_half_wr: assert property (
        s_half_go |-> ##2 (o_done && o_wr_en && o_wr_idx == $past(i_instr[11:8], 2)))
        else $error("halfword result not written to its destination");
    a_dsp_undef: assert property (
        i_valid && half_w && !i_dsp_ext |-> ##2 (o_done && o_undef && !o_wr_en))
        else $error("halfword form ran without the extension");
    a_word_undef: assert property (
        i_valid && lword_w && !i_main_ext |-> ##2 (o_undef && !o_wr_hi_en))
        else $error("word long form ran without the main extension");
    a_undef_quiet: assert property (
        o_undef |-> o_done && !o_wr_en && !o_wr_hi_en)
        else $error("undefined instruction wrote a register");
    a_cond_hold: assert property (
        i_valid && !i_cond_pass |-> ##2 !(o_wr_en || o_wr_hi_en))
        else $error("failed condition still wrote");
    a_flag_sticky: assert property (
        o_sat_flag && !i_sat_clear |=> o_sat_flag)
        else $error("saturation flag dropped without a clear");
    a_long_flag: assert property (
        s_long_go |-> ##2 !$rose(o_sat_flag))
        else $error("long form set the saturation flag");
    a_long_pair: assert property (
        s_long_go ##0 (!same_w && i_main_ext && i_dsp_ext) |-> ##2
            (o_wr_en && o_wr_hi_en && o_wr_hi_idx == $past(i_instr[11:8], 2)
            && o_wr_idx == $past(i_instr[15:12], 2)))
        else $error("long result halves not written as a pair");
    a_same_nop: assert property (
        s_long_go ##0 same_w |-> ##2 (o_done && !o_wr_en && !o_wr_hi_en))
        else $error("long form with one destination was not a no-op");
endmodule

// ---- smacu_rf_model.sv ----
// Register file model on the far side of the unit.
// Assumes reads answer the index at once and writes land one edge later.
`timescale 1ns/1ns
module smacu_rf_model (
    input wire logic i_clk,
    input wire logic [3:0] i_rn_idx,
    input wire logic [3:0] i_rm_idx,
    input wire logic [3:0] i_ra_idx,
    input wire logic [3:0] i_rd_idx,
    output logic [31:0] o_rn_val,
    output logic [31:0] o_rm_val,
    output logic [31:0] o_ra_val,
    output logic [31:0] o_rd_val,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_idx,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_hi_en,
    input wire logic [3:0] i_wr_hi_idx,
    input wire logic [31:0] i_wr_hi_data
);
    logic [31:0] regs [0:15]; // Preloaded by the bench between operations
    // Same-cycle reads, as the unit expects
    assign o_rn_val = regs[i_rn_idx];
    assign o_rm_val = regs[i_rm_idx];
    assign o_ra_val = regs[i_ra_idx];
    assign o_rd_val = regs[i_rd_idx];
    // Write-back of both result halves
    always @(posedge i_clk)
    begin
        if (i_wr_en)
            regs[i_wr_idx] <= i_wr_data;
        if (i_wr_hi_en)
            regs[i_wr_hi_idx] <= i_wr_hi_data;
    end
endmodule

// ---- testbench.sv ----
// Self-checking bench for smacu_core with a register file model.
// Assumes the two-cycle answer; operands use rn=1, rm=2, ra/lo=3, rd/hi=4.
`timescale 1ns/1ns
`include "smacu_regs.vh"
module testbench;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic i_valid = 1'h0;
    logic [31:0] i_instr = 32'h0;
    logic i_cond_pass = 1'h1;
    logic i_dsp_ext = 1'h1;
    logic i_main_ext = 1'h1;
    logic i_sat_clear = 1'h0;
    wire [3:0] rn_i, rm_i, ra_i, rd_i, o_wr_idx, o_wr_hi_idx;
    wire [31:0] rn_v, rm_v, ra_v, rd_v, o_wr_data, o_wr_hi_data;
    wire o_done, o_undef, o_unpred, o_wr_en, o_wr_hi_en, o_sat_flag;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] va, vb, vc, vd; // Operand values for the next issue
    logic signed [63:0] e; // Expected full result

    // Free-running core clock, 4 ns
    always #2 i_clk = ~i_clk;

    smacu_core smacu_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid),
        .i_instr(i_instr), .i_cond_pass(i_cond_pass), .i_dsp_ext(i_dsp_ext),
        .i_main_ext(i_main_ext), .o_rn_idx(rn_i), .o_rm_idx(rm_i), .o_ra_idx(ra_i),
        .o_rd_idx(rd_i), .i_rn_val(rn_v), .i_rm_val(rm_v), .i_ra_val(ra_v),
        .i_rd_val(rd_v), .i_sat_clear(i_sat_clear), .o_done(o_done), .o_undef(o_undef),
        .o_unpred(o_unpred), .o_wr_en(o_wr_en), .o_wr_idx(o_wr_idx), .o_wr_data(o_wr_data),
        .o_wr_hi_en(o_wr_hi_en), .o_wr_hi_idx(o_wr_hi_idx),
        .o_wr_hi_data(o_wr_hi_data), .o_sat_flag(o_sat_flag));
    smacu_rf_model smacu_rf_model_inst (.i_clk(i_clk), .i_rn_idx(rn_i), .i_rm_idx(rm_i),
        .i_ra_idx(ra_i), .i_rd_idx(rd_i), .o_rn_val(rn_v), .o_rm_val(rm_v),
        .o_ra_val(ra_v), .o_rd_val(rd_v), .i_wr_en(o_wr_en), .i_wr_idx(o_wr_idx),
        .i_wr_data(o_wr_data), .i_wr_hi_en(o_wr_hi_en), .i_wr_hi_idx(o_wr_hi_idx),
        .i_wr_hi_data(o_wr_hi_data));

    // Instruction word with fixed source fields
    function automatic logic [31:0] mk(input logic [11:0] op, input logic [3:0] ra,
        input logic [3:0] sub, input logic [3:0] rd);
        return {op, 4'h1, ra, rd, sub, 4'h2};
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Load operands after any write-back, issue one op, wait for its answer
    task automatic issue(input logic [31:0] ins, input logic cp);
        @(posedge i_clk);
        #1;
        smacu_rf_model_inst.regs[1] = va;
        smacu_rf_model_inst.regs[2] = vb;
        smacu_rf_model_inst.regs[3] = vc;
        smacu_rf_model_inst.regs[4] = vd;
        @(posedge i_clk);
        i_instr <= ins;
        i_cond_pass <= cp;
        i_valid <= 1'h1;
        @(posedge i_clk);
        i_valid <= 1'h0;
        // Answer pulses stand only in the cycle after the second edge
        @(posedge i_clk);
        #1;
    endtask

    // All four halfword selections
    task automatic t_half;
        va = 32'h7fff_8001;
        vb = 32'h0003_fffe;
        vc = 32'h0000_0010;
        for (int k = 0; k < 4; k++)
        begin
            e = $signed(k[1] ? va[31:16] : va[15:0]) * $signed(k[0] ? vb[31:16] : vb[15:0])
                + $signed(vc);
            issue(mk(`SMACU_OP_HALF, 4'h3, {2'h0, k[1:0]}, 4'h4), 1'h1);
            chk(o_wr_en, 1'h1);
            chk({o_done, o_unpred, o_wr_idx}, 6'h24);
            chk(o_wr_data, e[31:0]);
            chk(o_sat_flag, 1'h0);
        end
        $display("halfword selections finished");
    endtask

    // Overflow, stickiness, clear, plain forms
    task automatic t_sat;
        va = 32'h0000_8000;
        vb = 32'h0000_8000;
        vc = 32'h7fff_ffff;
        issue(mk(`SMACU_OP_HALF, 4'h3, 4'h0, 4'h4), 1'h1);
        chk(o_wr_data, 32'hbfff_ffff);
        chk(o_sat_flag, 1'h1);
        vc = 32'h0;
        issue(mk(`SMACU_OP_HALF, 4'h3, 4'h0, 4'h4), 1'h1);
        chk(o_sat_flag, 1'h1);
        @(posedge i_clk) i_sat_clear <= 1'h1;
        @(posedge i_clk) i_sat_clear <= 1'h0;
        @(posedge i_clk);
        #1;
        chk(o_sat_flag, 1'h0);
        issue(mk(`SMACU_OP_HALF, 4'hf, 4'h0, 4'h4), 1'h1);
        chk(o_wr_data, 32'h4000_0000);
        va = 32'h8000_8000;
        vb = 32'h8000_8000;
        issue(mk(`SMACU_OP_DUAL, 4'hf, 4'h0, 4'h4), 1'h1);
        chk(o_wr_data, 32'h8000_0000);
        chk(o_sat_flag, 1'h1);
        $display("saturation and plain forms finished");
    endtask

    // Dual with and without exchange
    task automatic t_dual;
        logic [31:0] op2;
        va = 32'h0002_fffd;
        vb = 32'h0005_0007;
        vc = 32'hffff_fff0;
        for (int m = 0; m < 2; m++)
        begin
            op2 = m[0] ? {vb[15:0], vb[31:16]} : vb;
            e = $signed(va[15:0]) * $signed(op2[15:0])
                + $signed(va[31:16]) * $signed(op2[31:16]) + $signed(vc);
            issue(mk(`SMACU_OP_DUAL, 4'h3, {3'h0, m[0]}, 4'h4), 1'h1);
            chk(o_wr_data, e[31:0]);
        end
        $display("dual forms finished");
    endtask

    // Word, halfword and exchanged dual long forms; the word and halfword ones wrap
    task automatic t_long;
        logic [3:0] sub [0:2];
        sub = '{4'h0, 4'ha, 4'hd};
        // Start from a clear flag so a wrong set by a long form shows
        @(posedge i_clk) i_sat_clear <= 1'h1;
        @(posedge i_clk) i_sat_clear <= 1'h0;
        va = 32'h8001_7ffe;
        vb = 32'h8000_fffd;
        vc = 32'hffff_ffff;
        vd = 32'h7fff_ffff;
        for (int k = 0; k < 3; k++)
        begin
            case (k)
                0: e = $signed(va) * $signed(vb) + $signed({vd, vc});
                1: e = $signed(va[31:16]) * $signed(vb[15:0]) + $signed({vd, vc});
                default: e = $signed(va[15:0]) * $signed(vb[31:16])
                    + $signed(va[31:16]) * $signed(vb[15:0]) + $signed({vd, vc});
            endcase
            issue(mk(`SMACU_OP_LONG, 4'h3, sub[k], 4'h4), 1'h1);
            chk(o_wr_data, e[31:0]);
            chk(o_wr_hi_data, e[63:32]);
            chk({o_wr_hi_idx, o_wr_idx}, 8'h43);
            chk({o_wr_en, o_wr_hi_en, o_sat_flag}, 3'h6);
        end
        $display("long forms finished");
    endtask

    // Missing extensions, failed condition, shared long destination
    task automatic t_refuse;
        @(posedge i_clk) i_dsp_ext <= 1'h0;
        issue(mk(`SMACU_OP_HALF, 4'h3, 4'h0, 4'h4), 1'h1);
        chk({o_undef, o_wr_en}, 2'h2);
        issue(mk(`SMACU_OP_LONG, 4'h3, 4'h0, 4'h4), 1'h1);
        chk({o_undef, o_wr_hi_en}, 2'h1);
        @(posedge i_clk)
        begin
            i_dsp_ext <= 1'h1;
            i_main_ext <= 1'h0;
        end
        issue(mk(`SMACU_OP_LONG, 4'h3, 4'h0, 4'h4), 1'h1);
        chk({o_undef, o_wr_hi_en}, 2'h2);
        @(posedge i_clk) i_main_ext <= 1'h1;
        issue(mk(`SMACU_OP_HALF, 4'h3, 4'h0, 4'h4), 1'h0);
        chk({o_done, o_wr_en}, 2'h2);
        issue(mk(`SMACU_OP_LONG, 4'h4, 4'h0, 4'h4), 1'h1);
        chk({o_done, o_wr_en, o_wr_hi_en}, 3'h4);
        // Stack pointer as destination: still executed, but reported
        issue(mk(`SMACU_OP_HALF, 4'h3, 4'h0, 4'hd), 1'h1);
        chk({o_done, o_unpred, o_wr_en, o_wr_idx}, 7'h7d);
        $display("refusals finished");
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence; accumulator 15 holds a value that must never be used
    initial
    begin
        smacu_rf_model_inst.regs[15] = 32'h1111_1111;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'h0;
        t_half;
        t_sat;
        t_dual;
        t_long;
        t_refuse;
        complete_run;
    end

    // Watchdog: nineteen ops of four cycles, with wide margin
    initial
    begin
        #20000;
        err_total++;
        complete_run;
    end
endmodule

bind smacu_core smacu_chk smacu_chk_inst (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid),
    .i_instr(i_instr), .i_cond_pass(i_cond_pass), .i_dsp_ext(i_dsp_ext),
    .i_main_ext(i_main_ext), .i_sat_clear(i_sat_clear), .o_done(o_done),
    .o_undef(o_undef), .o_wr_en(o_wr_en), .o_wr_idx(o_wr_idx), .o_wr_hi_en(o_wr_hi_en),
    .o_wr_hi_idx(o_wr_hi_idx), .o_sat_flag(o_sat_flag));
